// ---- rtl/sdip_regs.vh ----
// constants of the serial converter write port
`ifndef SDIP_REGS_VH
`define SDIP_REGS_VH
`define SDIP_WORD_BITS 16
`define SDIP_CODE_BITS 12
`define SDIP_CODE_LSB 0
`define SDIP_PD_LSB 14
`define SDIP_PD_BITS 2
`define SDIP_PD_NORMAL 2'h0
`define SDIP_CODE_RESET 12'h000
`define SDIP_SYNC_STAGES 3
`endif

// ---- rtl/sdip_sync.v ----
// three-stage input synchroniser with agreement filter
`default_nettype none
module sdip_sync #(
    parameter RESET_VAL = 1'b0
) (
    input wire mclk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_r <= RESET_VAL;
            s2_r <= RESET_VAL;
            s3_r <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            // change counts only once the two later stages agree
            if (s2_r == s3_r) begin
                dout <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sdip_top.v ----
// serial write port of a 12-bit voltage-output converter
`include "sdip_regs.vh"
`default_nettype none
module sdip_top #(
    parameter WORD_BITS = `SDIP_WORD_BITS,
    parameter CODE_BITS = `SDIP_CODE_BITS
) (
    input wire mclk,
    input wire rst,
    input wire frame_n,
    input wire sclk,
    input wire sdin,
    output reg [CODE_BITS-1:0] analog_out_code,
    output reg [1:0] pd_mode,
    output wire powered_down,
    output reg update_pulse,
    output reg abort_pulse
);
    wire frame_n_s;
    wire sclk_s;
    wire sdin_s;
    reg sclk_d_r;
    reg frame_n_d_r;
    reg [WORD_BITS-1:0] shift_r;
    reg [4:0] count_r;
    reg done_r;
    wire fall;
    wire frame_rise;

    sdip_sync #(.RESET_VAL(1'b1)) u_frame (
        .mclk(mclk),
        .rst(rst),
        .din(frame_n),
        .dout(frame_n_s)
    );
    sdip_sync #(.RESET_VAL(1'b1)) u_sclk (
        .mclk(mclk),
        .rst(rst),
        .din(sclk),
        .dout(sclk_s)
    );
    sdip_sync #(.RESET_VAL(1'b0)) u_sdin (
        .mclk(mclk),
        .rst(rst),
        .din(sdin),
        .dout(sdin_s)
    );

    assign fall = sclk_d_r & ~sclk_s;
    assign frame_rise = ~frame_n_d_r & frame_n_s;
    assign powered_down = (pd_mode != `SDIP_PD_NORMAL);

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sclk_d_r <= 1'b1;
            frame_n_d_r <= 1'b1;
            shift_r <= {WORD_BITS{1'b0}};
            count_r <= 5'h00;
            done_r <= 1'b0;
            analog_out_code <= `SDIP_CODE_RESET;
            pd_mode <= `SDIP_PD_NORMAL;
            update_pulse <= 1'b0;
            abort_pulse <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            frame_n_d_r <= frame_n_s;
            update_pulse <= 1'b0;
            abort_pulse <= 1'b0;
            if (frame_n_s) begin
                // idle or frame end: partial word dropped
                count_r <= 5'h00;
                done_r <= 1'b0;
                if (frame_rise && !done_r) begin
                    abort_pulse <= 1'b1;
                end
            end else if (fall && !done_r) begin
                shift_r <= {shift_r[WORD_BITS-2:0], sdin_s};
                if (count_r == WORD_BITS - 1) begin
                    // sixteenth edge: transfer word
                    done_r <= 1'b1;
                    update_pulse <= 1'b1;
                    // last bit still in sdin_s: word index n sits at n-1
                    analog_out_code <=
                        {shift_r[CODE_BITS-2:0], sdin_s};
                    pd_mode <=
                        shift_r[`SDIP_PD_LSB+`SDIP_PD_BITS-2 -: 2];
                    count_r <= 5'h00;
                end else begin
                    count_r <= count_r + 5'h01;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- verification/sdip_chk.sv ----
// assertions on the converter write port
`default_nettype none
module sdip_chk #(parameter CODE_BITS = 12) (input wire mclk, rst, frame_n,
    sclk, sdin, powered_down, update_pulse, abort_pulse,
    input wire [CODE_BITS-1:0] analog_out_code, input wire [1:0] pd_mode);
default clocking @(posedge mclk); endclocking
default disable iff (rst);
chk_code_upd:
    assert property ($changed(analog_out_code) |-> update_pulse) else $error("code moved");
chk_pd_upd:
    assert property ($changed(pd_mode) |-> update_pulse) else $error("mode moved");
chk_pd_flag:
    assert property (powered_down == (pd_mode != 0)) else $error("bad flag");
chk_abort_excl:
    assert property (abort_pulse |-> !update_pulse) else $error("both pulses");
chk_upd_frame:
    assert property (update_pulse |-> !$past(frame_n, 8)) else $error("no frame");
chk_upd_gap:
    assert property (update_pulse |=> !update_pulse [*8]) else $error("fast update");
endmodule
bind sdip_top sdip_chk #(.CODE_BITS(CODE_BITS)) u_sdip_chk (.*);
`default_nettype wire

// ---- verification/sdip_host.sv ----
// host model driving the three-wire write port
`default_nettype none
module sdip_host (output logic frame_n, output logic sclk, output logic sdin);
timeunit 1ns; timeprecision 1ps;
initial begin frame_n = 1; sclk = 1; sdin = 0; end
task automatic send(input logic [15:0] w, input int n);
    #3 frame_n = 0;
    for (int i = 15; i > 15 - n; i--) begin
        sdin = w[i];
        #40 sclk = 0;
        #40 sclk = 1;
    end
    sdin = ~sdin;
    #40 frame_n = 1;
    #200;
endtask
endmodule
`default_nettype wire

// ---- verification/sdip_top_tb.sv ----
// bench for the converter write port
`default_nettype none
module sdip_top_tb;
timeunit 1ns; timeprecision 1ps;
logic mclk = 0, rst = 1;
wire frame_n, sclk, sdin, powered_down, update_pulse, abort_pulse;
wire [11:0] analog_out_code;
wire [1:0] pd_mode;
int n_errors = 0, checked = 0, seed = 68;
logic [15:0] w, last = 0;
int n_upd = 0, n_abort = 0, n_full = 0, n_cut = 0;
always @(posedge mclk) begin
    if (update_pulse === 1'b1) n_upd++;
    if (abort_pulse === 1'b1) n_abort++;
end
always #5 mclk = ~mclk;
sdip_host u_sdip_host (.frame_n(frame_n), .sclk(sclk), .sdin(sdin));
sdip_top u_sdip_top (.mclk(mclk), .rst(rst), .frame_n(frame_n), .sclk(sclk),
    .sdin(sdin), .analog_out_code(analog_out_code), .pd_mode(pd_mode),
    .powered_down(powered_down), .update_pulse(update_pulse),
    .abort_pulse(abort_pulse));
function automatic logic [13:0] expect_of(input logic [15:0] v);
    return {v[15:14], v[11:0]};
endfunction
task automatic check(input logic [15:0] v);
    checked++;
    if ({pd_mode, analog_out_code} !== expect_of(v) ||
        powered_down !== (v[15:14] != 2'h0)) begin
        n_errors++;
        $display("unexpected at %0t: word %h", $time, analog_out_code);
    end
endtask
task automatic conclude;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
initial begin
    repeat (8) @(posedge mclk);
    #1 rst = 0;
    check(0);
    for (int k = 0; k < 13; k++) begin
        w = 16'($random(seed));
        if (k < 4) w[15:14] = k[1:0];
        u_sdip_host.send(w, (k < 8 || k == 12) ? 16 : (k - 8) * 5);
        if (k < 8 || k == 12) begin
            last = w;
            n_full++;
        end else begin
            n_cut++;
        end
        check(last);
        checked++;
        if (n_upd != n_full || n_abort != n_cut) begin
            n_errors++;
            $display("unexpected at %0t: pulses %0d %0d", $time, n_upd,
                n_abort);
        end
    end
    @(posedge mclk);
    #1 rst = 1;
    @(posedge mclk);
    #1 rst = 0;
    check(0);
    w = 16'($random(seed));
    u_sdip_host.send(w, 16);
    check(w);
    conclude;
end
initial begin #100us; n_errors++; conclude; end
endmodule
`default_nettype wire
